// ### dcb_consts.svh
// Register indices, field positions, reset values and mode codes for the
// diagnostic current and balance switch register bank.
// Assumes it is included by its bare name from the package; the modules do not include it.
`ifndef DCB_CONSTS_SVH
`define DCB_CONSTS_SVH

// Register indices; byte address is four times the index
`define DCB_IDX_CELL_TEST   8'h6C
`define DCB_IDX_AUX_TEST    8'h6D
`define DCB_IDX_DIAG_GEN    8'h6E
`define DCB_IDX_BAL_SW      8'h6F
`define DCB_IDX_CUR_CFG     8'h80
`define DCB_IDX_PIN_FUNC    8'h81

// Field positions
`define DCB_CELL_EN_MSB     14
`define DCB_AUX_EN_MSB      5
`define DCB_DIAG_SEL_MSB    15
`define DCB_DIAG_SEL_LSB    13
`define DCB_RESTART_BIT     15
`define DCB_BALSW_MSB       13
`define DCB_LEVEL_MSB       3
`define DCB_DIR_BIT         4
`define DCB_GPIO_MSB        5
`define DCB_I2C_BIT         6

// Reset values
`define DCB_RST_CELL_TEST   15'h0000
`define DCB_RST_AUX_TEST    6'h00
`define DCB_RST_DIAG_SEL    3'h0
`define DCB_RST_BALSW       14'h0000
`define DCB_RST_LEVEL       4'h0
`define DCB_RST_PIN_FUNC    7'h00

// Balancing mode codes
`define DCB_CB_MODE_OFF     3'h0
`define DCB_CB_MODE_AUTO1   3'h1
`define DCB_CB_MODE_MANUAL  3'h3

`endif

// ### dcb_pkg.sv
// Types shared by the diagnostic current and balance switch register bank.
// Assumes dcb_consts.svh is on the include path.
package dcb_pkg;
  `include "dcb_consts.svh"

  // Auxiliary diagnostic mode codes
  typedef enum logic [2:0] {
    DCB_AUX_NORMAL0   = 3'b000,
    DCB_AUX_NORMAL1   = 3'b001,
    DCB_AUX_DISCHARGE = 3'b010,
    DCB_AUX_THERMISTOR_BIAS_OUTPUT_GND  = 3'b011,
    DCB_AUX_RSV4      = 3'b100,
    DCB_AUX_RSV5      = 3'b101,
    DCB_AUX_RSV6      = 3'b110,
    DCB_AUX_RSV7      = 3'b111
  } dcb_aux_mode_type;

  // Drive toward the six auxiliary input ports
  typedef struct packed {
    logic [5:0] current_en;  // Effective test current enables
    logic [5:0] discharge;   // Accelerated discharge applied
    logic [5:0] thermistor_bias_output_gnd;    // Thermistor bias tied to ground
  } dcb_aux_drive_type;

  // Shared test current setting
  typedef struct packed {
    logic [3:0] level;       // Test current level
    logic       direction;   // Test current direction
  } dcb_current_cfg_type;
endpackage

// ### dcb_aux_gate.sv
// Auxiliary port gating: masks test current enables and diagnostic modes
// for ports that are not in analog input function.
// Assumes inputs come from registers on the same clock.
`timescale 1ns/1ps
module dcb_aux_gate
  import dcb_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic [5:0]        aux_en_stored,
  input  wire logic [5:0]        aux_pin_gpio_select,
  input  wire logic              digital_i2c_pin_select,
  input  wire dcb_aux_mode_type  mode,
  output dcb_aux_drive_type      drive
);
  logic [5:0]        i2c_mask;     // Ports taken by the I2C function
  logic [5:0]        analog_port;  // Ports in analog input function
  dcb_aux_drive_type drive_next;   // Next output value

  // I2C function claims ports one and zero only
  assign i2c_mask = {4'h0, {2{digital_i2c_pin_select}}}; // RULE5
  assign analog_port = ~aux_pin_gpio_select & ~i2c_mask; // RULE4
  // Stored enables still read back; only the drive is masked
  assign drive_next.current_en = aux_en_stored & analog_port; // RULE3
  // Diagnostic modes touch analog ports only
  assign drive_next.discharge =
    (mode == DCB_AUX_DISCHARGE) ? analog_port : 6'h00; // RULE7
  assign drive_next.thermistor_bias_output_gnd =
    (mode == DCB_AUX_THERMISTOR_BIAS_OUTPUT_GND) ? analog_port : 6'h00; // RULE6

  // Output register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drive <= '0;
    end else begin
      drive <= drive_next;
    end
  end
endmodule

// ### dcb_regs.sv
// Diagnostic current source and balance switch register bank, APB slave.
// Assumes balancing mode and timer expiry come from same-clock logic.
//
// Summary of operation
// RULE1 - Fifteen cell test current enable bits
// RULE2 - Current level comes from separate config
// RULE3 - Six aux enables, shared level and direction
// RULE4 - GPIO ports ignore aux enable, readback kept
// RULE5 - I2C select masks aux enables one, zero
// RULE6 - Three-bit aux diag mode decode
// RULE7 - Aux diag mode affects analog ports only
// RULE8 - Software pairs cell open with aux 010/011
// RULE9 - Switch writes dropped in modes 001, 1xx
// RULE10 - Restart one resets balance timer
// RULE11 - Restart is strobe, reads zero
// RULE12 - Restart acts in manual mode only
// RULE13 - Restart ignored after timer expiry
// RULE14 - Fourteen balance switch enable bits
// RULE15 - Software enables pull-downs for open check
// RULE16 - Unused bits read zero, ignore writes
`timescale 1ns/1ps
module dcb_regs
  import dcb_pkg::*;
#(
  parameter int PADDR_W = 12
)(
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [PADDR_W-1:0] paddr,
  input  wire logic [31:0]        pwdata,
  input  wire logic [3:0]         pstrb,
  output logic [31:0]             prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic [2:0]         balancing_mode,
  input  wire logic               balance_timer_expired,
  output logic [14:0]             cell_test_current_enable,
  output dcb_current_cfg_type     test_current_cfg,
  output dcb_aux_drive_type       aux_drive,
  output dcb_aux_mode_type        aux_diag_mode_select,
  output logic [13:0]             balance_switch_enable,
  output logic                    balance_timer_restart
);
  // Index match with aligned word check
  function automatic logic dcb_hit(input logic [PADDR_W-1:0] addr,
                                   input logic [7:0]         idx);
    dcb_hit = (addr[PADDR_W-1:2] == {{(PADDR_W-10){1'b0}}, idx}) &&
              (addr[1:0] == 2'b00);
  endfunction

  // Stored register fields
  logic [14:0]      cell_en_reg;       // Cell test current enables
  logic [5:0]       aux_en_reg;        // Aux enables as written
  dcb_aux_mode_type diag_sel_reg;      // Aux diagnostic mode
  logic [13:0]      balsw_reg;         // Balance switch enables
  logic [3:0]       level_reg;         // Test current level
  logic             dir_reg;           // Test current direction
  logic [5:0]       gpio_sel_reg;      // Aux ports in GPIO function
  logic             i2c_sel_reg;       // Ports one, zero in I2C function
  logic             restart_reg;       // Timer restart pulse
  logic [31:0]      prdata_reg;        // Captured read data
  logic             pslverr_reg;       // Captured error answer

  // Next values
  logic [14:0]      cell_en_next;
  logic [5:0]       aux_en_next;
  dcb_aux_mode_type diag_sel_next;
  logic [13:0]      balsw_next;
  logic [3:0]       level_next;
  logic             dir_next;
  logic [5:0]       gpio_sel_next;
  logic             i2c_sel_next;
  logic             restart_next;
  logic [31:0]      prdata_next;
  logic             pslverr_next;

  // Address decode
  logic hit_cell;      // Cell test current register
  logic hit_aux;       // Aux test current register
  logic hit_diag;      // General diagnostic register
  logic hit_balsw;     // Balance switch register
  logic hit_cur;       // Test current level register
  logic hit_pin;       // Aux pin function register
  logic hit_any;       // Any mapped register

  // Bus phases
  logic setup_phase;   // First cycle of a transfer
  logic wr_access;     // Write completes this edge
  logic lo_en;         // Low byte lane written
  logic hi_en;         // High byte lane written

  // Balancing qualifiers
  logic balsw_blocked; // Automated balancing holds the switches
  logic manual_mode;   // Manual balancing selected
  logic restart_ok;    // Restart write honoured

  // Read view of each register
  logic [31:0] rd_cell;
  logic [31:0] rd_aux;
  logic [31:0] rd_diag;
  logic [31:0] rd_balsw;
  logic [31:0] rd_cur;
  logic [31:0] rd_pin;

  // Decode of the six register words
  assign hit_cell  = dcb_hit(paddr, `DCB_IDX_CELL_TEST);
  assign hit_aux   = dcb_hit(paddr, `DCB_IDX_AUX_TEST);
  assign hit_diag  = dcb_hit(paddr, `DCB_IDX_DIAG_GEN);
  assign hit_balsw = dcb_hit(paddr, `DCB_IDX_BAL_SW);
  assign hit_cur   = dcb_hit(paddr, `DCB_IDX_CUR_CFG);
  assign hit_pin   = dcb_hit(paddr, `DCB_IDX_PIN_FUNC);
  assign hit_any   = hit_cell | hit_aux | hit_diag | hit_balsw |
                     hit_cur | hit_pin;

  // Transfer phases; the slave never inserts wait states
  assign setup_phase = psel & ~penable;
  assign wr_access   = psel & penable & pwrite & hit_any;
  assign lo_en       = pstrb[0];
  assign hi_en       = pstrb[1];

  // Automated modes 001 and 1xx lock the switch register
  assign balsw_blocked = (balancing_mode == `DCB_CB_MODE_AUTO1) |
                         balancing_mode[2]; // RULE9
  assign manual_mode   = (balancing_mode == `DCB_CB_MODE_MANUAL); // RULE12
  // Restart only in manual mode and before the timer has run out
  assign restart_ok    = wr_access & hit_balsw & ~balsw_blocked & hi_en &
                         pwdata[`DCB_RESTART_BIT] & manual_mode &
                         ~balance_timer_expired; // RULE13

  // Read views; unused bits are zero
  assign rd_cell  = {16'h0000, 1'b0, cell_en_reg}; // RULE16
  assign rd_aux   = {26'h0, aux_en_reg}; // RULE4
  assign rd_diag  = {16'h0000, diag_sel_reg, 13'h0000}; // RULE16
  // Restart bit always reads zero
  assign rd_balsw = {16'h0000, 2'b00, balsw_reg}; // RULE11
  assign rd_cur   = {27'h0, dir_reg, level_reg};
  assign rd_pin   = {25'h0, i2c_sel_reg, gpio_sel_reg};

  // Read mux, captured in the setup cycle
  assign prdata_next =
    ~setup_phase ? prdata_reg :
    pwrite       ? 32'h00000000 :
    hit_cell     ? rd_cell :
    hit_aux      ? rd_aux :
    hit_diag     ? rd_diag :
    hit_balsw    ? rd_balsw :
    hit_cur      ? rd_cur :
    hit_pin      ? rd_pin : 32'h00000000;
  // Unmapped addresses answer with an error
  assign pslverr_next = setup_phase ? ~hit_any : pslverr_reg;

  // Cell test current enables, bits 14:8 in high lane
  assign cell_en_next[7:0] = (wr_access & hit_cell & lo_en) ?
                             pwdata[7:0] : cell_en_reg[7:0]; // RULE1
  assign cell_en_next[14:8] =
    (wr_access & hit_cell & hi_en) ?
    pwdata[`DCB_CELL_EN_MSB:8] : cell_en_reg[14:8]; // RULE1

  // Aux enables stored as written, whatever the pin function
  assign aux_en_next = (wr_access & hit_aux & lo_en) ?
                       pwdata[`DCB_AUX_EN_MSB:0] : aux_en_reg; // RULE3

  // Aux diagnostic mode field
  assign diag_sel_next =
    (wr_access & hit_diag & hi_en) ?
    dcb_aux_mode_type'(pwdata[`DCB_DIAG_SEL_MSB:`DCB_DIAG_SEL_LSB]) :
    diag_sel_reg; // RULE6

  // Balance switch enables, dropped while automated balancing runs
  assign balsw_next[7:0] =
    (wr_access & hit_balsw & lo_en & ~balsw_blocked) ?
    pwdata[7:0] : balsw_reg[7:0]; // RULE9
  assign balsw_next[13:8] =
    (wr_access & hit_balsw & hi_en & ~balsw_blocked) ?
    pwdata[`DCB_BALSW_MSB:8] : balsw_reg[13:8]; // RULE14

  // Shared test current level and direction
  assign level_next = (wr_access & hit_cur & lo_en) ?
                      pwdata[`DCB_LEVEL_MSB:0] : level_reg; // RULE2
  assign dir_next   = (wr_access & hit_cur & lo_en) ?
                      pwdata[`DCB_DIR_BIT] : dir_reg; // RULE3

  // Aux pin function selects
  assign gpio_sel_next = (wr_access & hit_pin & lo_en) ?
                         pwdata[`DCB_GPIO_MSB:0] : gpio_sel_reg;
  assign i2c_sel_next  = (wr_access & hit_pin & lo_en) ?
                         pwdata[`DCB_I2C_BIT] : i2c_sel_reg;

  // One-cycle restart strobe, never stored
  assign restart_next = restart_ok; // RULE10

  // Configuration fields
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cell_en_reg  <= `DCB_RST_CELL_TEST;
      aux_en_reg   <= `DCB_RST_AUX_TEST;
      diag_sel_reg <= DCB_AUX_NORMAL0;
      level_reg    <= `DCB_RST_LEVEL;
      dir_reg      <= 1'b0;
    end else begin
      cell_en_reg  <= cell_en_next;
      aux_en_reg   <= aux_en_next;
      diag_sel_reg <= diag_sel_next;
      level_reg    <= level_next;
      dir_reg      <= dir_next;
    end
  end

  // Pin function and balancing fields
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gpio_sel_reg <= 6'h00;
      i2c_sel_reg  <= 1'b0;
      balsw_reg    <= `DCB_RST_BALSW;
      restart_reg  <= 1'b0;
    end else begin
      gpio_sel_reg <= gpio_sel_next;
      i2c_sel_reg  <= i2c_sel_next;
      balsw_reg    <= balsw_next;
      restart_reg  <= restart_next; // RULE11
    end
  end

  // Bus answer registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg  <= 32'h00000000;
      pslverr_reg <= 1'b0;
    end else begin
      prdata_reg  <= prdata_next;
      pslverr_reg <= pslverr_next;
    end
  end

  // Port masking and mode decode for the aux inputs
  dcb_aux_gate u_aux_gate (
    .pclk                   (pclk),
    .presetn                (presetn),
    .aux_en_stored          (aux_en_reg),
    .aux_pin_gpio_select    (gpio_sel_reg),
    .digital_i2c_pin_select (i2c_sel_reg),
    .mode                   (diag_sel_reg),
    .drive                  (aux_drive)
  );

  // Outputs
  assign prdata                       = prdata_reg;
  assign pready                       = 1'b1;
  assign pslverr                      = pslverr_reg & psel & penable;
  assign cell_test_current_enable     = cell_en_reg;
  assign test_current_cfg.level       = level_reg;
  assign test_current_cfg.direction   = dir_reg;
  assign aux_diag_mode_select         = diag_sel_reg;
  assign balance_switch_enable        = balsw_reg;
  assign balance_timer_restart        = restart_reg;
endmodule

// ### dcb_regs_monitor.sv
// Concurrent checks on the ports of the register bank.
// Assumes it is bound to dcb_regs and sees only that module's ports.
`timescale 1ns/1ps
module dcb_regs_monitor
  import dcb_pkg::*;
#(
  parameter int PADDR_W = 12
)(
  input wire logic                pclk,
  input wire logic                presetn,
  input wire logic                psel,
  input wire logic                penable,
  input wire logic                pwrite,
  input wire logic [PADDR_W-1:0]  paddr,
  input wire logic [31:0]         pwdata,
  input wire logic [3:0]          pstrb,
  input wire logic [31:0]         prdata,
  input wire logic [2:0]          balancing_mode,
  input wire logic                balance_timer_expired,
  input wire logic [14:0]         cell_test_current_enable,
  input wire dcb_current_cfg_type test_current_cfg,
  input wire dcb_aux_drive_type   aux_drive,
  input wire dcb_aux_mode_type    aux_diag_mode_select,
  input wire logic [13:0]         balance_switch_enable,
  input wire logic                balance_timer_restart
);
  // Access phase, write to the switch register, modes that allow it
  wire logic acc     = psel && penable;
  wire logic wr_sw   = acc && pwrite && paddr == 12'h1BC;
  wire logic sw_open = balancing_mode != 3'h1 && !balancing_mode[2];
  // Restart write that must reach the balance timer
  wire logic rs_ok   = wr_sw && pstrb[1] && pwdata[15] &&
                       balancing_mode == 3'h3 && !balance_timer_expired;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  cell_write_a: assert property (
    acc && pwrite && paddr == 12'h1B0 && pstrb == 4'hF |=>
    cell_test_current_enable == $past(pwdata[14:0]))
    else $error("cell enables not taken from write");
  level_write_a: assert property (
    acc && pwrite && paddr == 12'h200 && pstrb == 4'hF |=>
    {test_current_cfg.direction, test_current_cfg.level} == $past(pwdata[4:0]))
    else $error("current level not taken from write");
  sw_write_a: assert property (
    wr_sw && sw_open && pstrb == 4'hF |=>
    balance_switch_enable == $past(pwdata[13:0]))
    else $error("switch enables not taken from write");
  sw_block_a: assert property (
    !(wr_sw && sw_open) |=> $stable(balance_switch_enable))
    else $error("switch enables changed without open write");
  restart_fire_a: assert property (
    rs_ok |=> balance_timer_restart)
    else $error("restart write gave no pulse");
  restart_gate_a: assert property (
    balance_timer_restart |-> $past(rs_ok))
    else $error("restart pulse without accepted write");
  restart_pulse_a: assert property (
    balance_timer_restart |=> !balance_timer_restart)
    else $error("restart pulse longer than one cycle");
  restart_read_a: assert property (
    acc && !pwrite && paddr == 12'h1BC |-> prdata[31:14] == 18'h0)
    else $error("restart or unused bits read nonzero");
  discharge_a: assert property (
    aux_drive.discharge != 6'h0 |->
    $past(aux_diag_mode_select) == DCB_AUX_DISCHARGE)
    else $error("discharge outside its mode");
  thermistor_bias_output_gnd_a: assert property (
    aux_drive.thermistor_bias_output_gnd != 6'h0 |->
    $past(aux_diag_mode_select) == DCB_AUX_THERMISTOR_BIAS_OUTPUT_GND)
    else $error("bias grounded outside its mode");
endmodule

// ### diag_current_and_balance_switch_regs_test.sv
// Self-checking bench for the diagnostic current and balance switch bank.
// Assumes dcb_pkg, dcb_regs and dcb_regs_monitor are compiled first.
`timescale 1ns/1ps
module diag_current_and_balance_switch_regs_test;
  import dcb_pkg::*;
  logic                pclk, presetn, psel, penable, pwrite, look;
  logic [11:0]         paddr;
  logic [31:0]         pwdata, prdata;
  logic [3:0]          pstrb;
  logic                pready, pslverr;
  logic [2:0]          balancing_mode;
  logic                balance_timer_expired, balance_timer_restart;
  logic [14:0]         cell_test_current_enable;
  logic [13:0]         balance_switch_enable;
  dcb_current_cfg_type test_current_cfg;
  dcb_aux_drive_type   aux_drive;
  dcb_aux_mode_type    aux_diag_mode_select;
  int                  errors, n_tests;
  logic [32:0]         rq[$];   // Expected pslverr and read data
  logic [17:0]         dq[$];   // Expected aux drive
  int                  pq[$];   // One note per expected restart pulse
  logic [15:0]         mir[6];  // Mirror of register contents
  // Byte addresses and readable bits of the six registers
  localparam logic [11:0] addr_tab[6] = '{12'h1B0, 12'h1B4, 12'h1B8,
                                          12'h1BC, 12'h200, 12'h204};
  localparam logic [15:0] mask_tab[6] = '{16'h7FFF, 16'h003F, 16'hE000,
                                          16'h3FFF, 16'h001F, 16'h007F};

  dcb_regs #(.PADDR_W(12)) dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .balancing_mode, .balance_timer_expired,
    .cell_test_current_enable, .test_current_cfg, .aux_drive,
    .aux_diag_mode_select, .balance_switch_enable, .balance_timer_restart);

  // Prints the counts and the verdict, then stops
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Counts one comparison and reports a mismatch
  task automatic chk(string nm, logic [32:0] e, logic [32:0] g);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One APB transfer: setup, then access held until pready
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= 4'hF;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 20) begin
      errors++;
      print_verdict();
    end
  endtask

  // Write, then note the effect that the rules give it
  task automatic wr(int i, logic [31:0] d);
    apb(1'b1, addr_tab[i], d);
    if (i != 3 || (balancing_mode != 3'h1 && !balancing_mode[2]))
      mir[i] = d[15:0] & mask_tab[i];
    if (i == 3 && d[15] && balancing_mode == 3'h3 && !balance_timer_expired)
      pq.push_back(1);
  endtask

  // Read with the mirror as the expected value
  task automatic rd(int i);
    rq.push_back({1'b0, 16'h0, mir[i]});
    apb(1'b0, addr_tab[i], 32'h0);
  endtask

  // Asks the watcher to compare the aux drive once it has settled
  task automatic ax(logic [17:0] e);
    repeat (2) @(posedge pclk);
    dq.push_back(e);
    look <= 1'b1;
    @(posedge pclk);
    look <= 1'b0;
  endtask

  // Takes the oldest note whenever a result shows at the ports
  always @(posedge pclk) begin
    if (psel && penable && !pwrite && pready === 1'b1 && rq.size() > 0)
      chk("read", rq.pop_front(), {pslverr, prdata});
    if (look)
      chk("aux_drive", {15'h0, dq.pop_front()}, {15'h0, aux_drive});
    if (balance_timer_restart !== 1'b0) begin
      n_tests++;
      if (pq.size() == 0) begin
        errors++;
        $display("[FAIL] restart expected 0 seen %b", balance_timer_restart);
      end else
        pq.delete(0);
    end
  end

  // Free-running bus clock
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  // Main sequence
  initial begin
    logic [6:0] pin;
    logic [5:0] ms, a6;
    {presetn, psel, penable, pwrite, look, balance_timer_expired} = '0;
    {paddr, pwdata, pstrb, balancing_mode} = '0;
    errors = 0;
    n_tests = 0;
    foreach (mir[i]) mir[i] = 16'h0;
    void'($urandom(95));
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 6; i++) rd(i);
    apb(1'b1, 12'h1C0, $urandom);
    foreach (addr_tab[i]) begin
      rq.push_back({1'b1, 32'h0});
      apb(1'b0, addr_tab[i] + 12'h1 + 12'(i / 5 * 11), 32'h0);
    end
    $display("test reset_and_unmapped done");
    for (int k = 0; k < 4; k++)
      for (int i = 0; i < 6; i++) begin
        wr(i, $urandom);
        rd(i);
      end
    $display("test random_readback done");
    wr(0, 32'h00007FFF);
    rd(0);
    for (int p = 0; p < 3; p++) begin
      pin = (p == 0) ? 7'h45 : 7'($urandom);
      ms = ~(pin[5:0] | {4'h0, {2{pin[6]}}});
      a6 = 6'($urandom);
      wr(5, {25'h0, pin});
      wr(1, {26'h0, a6});
      for (int md = 0; md < 8; md++) begin
        wr(2, 32'(md) << 13);
        ax({a6 & ms, md == 2 ? ms : 6'h0, md == 3 ? ms : 6'h0});
      end
      rd(1);
    end
    $display("test aux_gating done");
    for (int i = 0; i < 16; i++) begin
      balancing_mode <= 3'(i);
      balance_timer_expired <= i[3];
      wr(3, $urandom | 32'h8000);
      rd(3);
    end
    repeat (2) @(posedge pclk);
    $display("test balance_modes done");
    chk("open notes", 33'h0, 33'(rq.size() + pq.size()));
    print_verdict();
  end
endmodule

bind dcb_regs dcb_regs_monitor #(.PADDR_W(PADDR_W)) mon (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
  .prdata, .balancing_mode, .balance_timer_expired,
  .cell_test_current_enable, .test_current_cfg, .aux_drive,
  .aux_diag_mode_select, .balance_switch_enable, .balance_timer_restart);
